// file: core/crr_map.svh
`ifndef CRR_MAP_SVH
`define CRR_MAP_SVH

// Register indices; byte address is four times the index
`define CRR_IDX_CHAN12     8'h52
`define CRR_IDX_CHAN13     8'h53
`define CRR_IDX_CTRL       8'h60
`define CRR_IDX_STAT       8'h61

// Result register layout
`define CRR_RESULT_W       16
`define CRR_RES_MSB        15
`define CRR_RES_LSB        2
`define CRR_CODE_W         14
`define CRR_RESULT_RST     16'h0000
`define CRR_CODE_RST       14'h0000

// Full code span covers this input range
`define CRR_FULL_SCALE_MV  5000

// Control register fields and reset value
`define CRR_CTRL_W         3
`define CRR_CTRL_RST       3'h3
`define CRR_CTRL_EN_LSB    0
`define CRR_CTRL_FILT_BIT  2

// Status register fields
`define CRR_STAT_FRESH_LSB 0
`define CRR_STAT_SKIP_LSB  2

// Acquisition channel numbering
`define CRR_CHAN_ID_W      4
`define CRR_CHAN_FIRST     4'hc
`define CRR_NUM_CHAN       2

// Bus geometry
`define CRR_ADR_W          10
`define CRR_DAT_W          32
`define CRR_SEL_W          4

`endif

// file: core/crr_pkg.sv
`include "crr_map.svh"

package crr_pkg;

  // One result from the acquisition engine
  typedef struct packed {
    logic                      valid;
    logic [`CRR_CHAN_ID_W-1:0] chan;
    logic [`CRR_CODE_W-1:0]    alu;
    logic [`CRR_CODE_W-1:0]    iir;
  } crr_sample_t;

  typedef struct packed {
    logic                  cyc;
    logic                  stb;
    logic                  we;
    logic [`CRR_ADR_W-1:0] adr;
    logic [`CRR_SEL_W-1:0] sel;
    logic [`CRR_DAT_W-1:0] dat;
  } crr_wb_req_t;

  typedef struct packed {
    logic                  ack;
    logic [`CRR_DAT_W-1:0] dat;
  } crr_wb_rsp_t;

endpackage

// file: core/crr_chan_store.sv
`timescale 1ns/10ps
`include "crr_map.svh"

module crr_chan_store
(
  input  wire logic                         i_clk,
  input  wire logic                         i_resetn,
  input  wire logic                         i_hit,
  input  wire logic                         i_scan_en,
  input  wire logic [`CRR_CODE_W-1:0]       i_alu,
  input  wire logic [`CRR_CODE_W-1:0]       i_iir,
  input  wire logic                         i_filt_sel,
  output logic      [`CRR_RESULT_W-1:0]     o_readback,
  output logic                              o_updated,
  output logic                              o_skipped
);

  logic [`CRR_CODE_W-1:0] alu_q;
  logic [`CRR_CODE_W-1:0] iir_q;
  logic                   skipped_q;

  ////////////////////////////////////////////////////////////////////////////
  // Both results kept so the select can flip without a new scan
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      alu_q <= `CRR_CODE_RST;
      iir_q <= `CRR_CODE_RST;
    end
    else if (i_hit && i_scan_en)
    begin
      alu_q <= i_alu;
      iir_q <= i_iir;
    end
  end

  // Disabled channel keeps old data, only the skip mark moves
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      skipped_q <= 1'b0;
    else if (i_hit)
      skipped_q <= !i_scan_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Select applies to stale data as well
  always_comb
  begin
    o_readback = {(i_filt_sel ? iir_q : alu_q), 2'b00};
  end

  assign o_updated = i_hit && i_scan_en;
  assign o_skipped = skipped_q;

endmodule

// file: core/crr_top.sv
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
`include "crr_map.svh"

// Functional notes
// - 14-bit result sits in bits 15:2, MSB in bit 15.
// - Full 14-bit code span represents a five volt input range.
// - Skipped channel (scan disabled) keeps its stored result unchanged.
// - Filter readback select picks ALU or IIR result, even when skipped.
// - Result registers current only for scanned channels, read-only, reset to zero.
module crr_top
(
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire crr_pkg::crr_wb_req_t i_wb,
  output crr_pkg::crr_wb_rsp_t      o_wb,
  input  wire crr_pkg::crr_sample_t i_sample
);

  import crr_pkg::*;

  localparam int NCH    = `CRR_NUM_CHAN;
  localparam int IDX_W  = `CRR_ADR_W - 2;
  localparam int CHID_W = `CRR_CHAN_ID_W;

  // Reset value is split into its fields below
  localparam logic [`CRR_CTRL_W-1:0] CTRL_RST = `CRR_CTRL_RST;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic idx_hit
  (
    input logic [`CRR_ADR_W-1:0] adr,
    input logic [IDX_W-1:0]      idx
  );
    idx_hit = (adr[`CRR_ADR_W-1:2] == idx);
  endfunction

  function automatic logic [`CRR_DAT_W-1:0] widen16
  (
    input logic [`CRR_RESULT_W-1:0] v
  );
    widen16 = {{(`CRR_DAT_W-`CRR_RESULT_W){1'b0}}, v};
  endfunction

  function automatic logic [`CRR_DAT_W-1:0] widen_ctrl
  (
    input logic [`CRR_CTRL_W-1:0] v
  );
    widen_ctrl = {{(`CRR_DAT_W-`CRR_CTRL_W){1'b0}}, v};
  endfunction

  function automatic logic [`CRR_DAT_W-1:0] stat_word
  (
    input logic [NCH-1:0] fresh,
    input logic [NCH-1:0] skip
  );
    logic [`CRR_DAT_W-1:0] w;
    w                             = '0;
    w[`CRR_STAT_FRESH_LSB +: NCH] = fresh;
    w[`CRR_STAT_SKIP_LSB +: NCH]  = skip;
    stat_word                     = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic                     ack_q;
  logic [`CRR_DAT_W-1:0]    dat_q;
  logic [NCH-1:0]           scan_en_q;
  logic                     filt_sel_q;
  logic [`CRR_CTRL_W-1:0]   ctrl_word;
  logic [NCH-1:0]           fresh_q;
  logic [NCH-1:0]           fresh_d;
  logic [NCH-1:0]           updated;
  logic [NCH-1:0]           skipped;
  logic [NCH-1:0]           sel_res;
  logic [NCH-1:0]           res_rd;
  logic [`CRR_RESULT_W-1:0] readback [NCH];
  logic                     sel_ctrl;
  logic                     sel_stat;
  logic                     access;
  logic                     rd_take;
  logic                     wr_ctrl;
  logic [`CRR_DAT_W-1:0]    rd_d;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  // One access per request; ack high in between blocks a double take

  assign access   = i_wb.cyc && i_wb.stb && !ack_q;
  assign rd_take  = access && !i_wb.we;
  assign sel_ctrl = idx_hit(i_wb.adr, `CRR_IDX_CTRL);
  assign sel_stat = idx_hit(i_wb.adr, `CRR_IDX_STAT);
  assign wr_ctrl  = access && i_wb.we && i_wb.sel[0] && sel_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel result stores

  for (genvar c = 0; c < NCH; c++)
  begin : g_chan
    logic             hit;
    logic [IDX_W-1:0] res_idx;

    assign res_idx    = `CRR_IDX_CHAN12 + IDX_W'(c);
    assign hit        = i_sample.valid
                     && (i_sample.chan == `CRR_CHAN_FIRST + CHID_W'(c));
    assign sel_res[c] = idx_hit(i_wb.adr, res_idx);
    assign res_rd[c]  = rd_take && sel_res[c];

    crr_chan_store u_store
    (
      .i_clk      (i_clk),
      .i_resetn   (i_resetn),
      .i_hit      (hit),
      .i_scan_en  (scan_en_q[c]),
      .i_alu      (i_sample.alu),
      .i_iir      (i_sample.iir),
      .i_filt_sel (filt_sel_q),
      .o_readback (readback[c]),
      .o_updated  (updated[c]),
      .o_skipped  (skipped[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan enables

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      scan_en_q <= CTRL_RST[`CRR_CTRL_EN_LSB +: NCH];
    else if (wr_ctrl)
      scan_en_q <= i_wb.dat[`CRR_CTRL_EN_LSB +: NCH];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filter readback select; flips the view of stored data at once

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      filt_sel_q <= CTRL_RST[`CRR_CTRL_FILT_BIT];
    else if (wr_ctrl)
      filt_sel_q <= i_wb.dat[`CRR_CTRL_FILT_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control readback

  always_comb
  begin
    ctrl_word                          = '0;
    ctrl_word[`CRR_CTRL_EN_LSB +: NCH] = scan_en_q;
    ctrl_word[`CRR_CTRL_FILT_BIT]      = filt_sel_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fresh flags: set by a stored update, cleared by reading the result.
  // Set wins so an update landing on the read is never lost.

  always_comb
  begin
    fresh_d = (fresh_q & ~res_rd) | updated;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      fresh_q <= '0;
    else
      fresh_q <= fresh_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; writes to result registers fall through untouched

  always_comb
  begin
    rd_d = '0;
    for (int c = 0; c < NCH; c++)
    begin
      if (sel_res[c])
        rd_d = widen16(readback[c]);
    end
    if (sel_ctrl)
      rd_d = widen_ctrl(ctrl_word);
    if (sel_stat)
      rd_d = stat_word(fresh_q, skipped);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone answer: one wait state, ack for exactly one cycle.
  // Unmapped addresses are acked with zero data, never stall the bus.

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      ack_q <= 1'b0;
    else
      ack_q <= access;
  end

  // Writes answer with zero so an old read word never reappears
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      dat_q <= '0;
    else if (rd_take)
      dat_q <= rd_d;
    else if (access)
      dat_q <= '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, straight from the answer flops

  assign o_wb.ack = ack_q;
  assign o_wb.dat = dat_q;

endmodule

// file: verif/crr_top_sva.sv
`timescale 1ns/10ps
`include "crr_map.svh"

module crr_top_sva
(
  input wire logic                  i_clk,
  input wire logic                  i_resetn,
  input wire crr_pkg::crr_wb_req_t  i_wb,
  input wire crr_pkg::crr_wb_rsp_t  o_wb,
  input wire crr_pkg::crr_sample_t  i_sample
);
  import crr_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic res;
  assign res = i_wb.adr[9:2] inside {`CRR_IDX_CHAN12, `CRR_IDX_CHAN13};
  sequence s_take;
    i_wb.cyc && i_wb.stb && !o_wb.ack;
  endsequence
  sequence s_res_ack;
    o_wb.ack && res;
  endsequence
  chk_ack_one_pulse:
    assert property (s_take |=> o_wb.ack ##1 !o_wb.ack) else $error("ack");
  chk_ack_has_cause:
    assert property (o_wb.ack |-> $past(i_wb.stb)) else $error("stray ack");
  chk_low_bits_zero:
    assert property (s_res_ack |-> o_wb.dat[1:0] == 2'h0) else $error("low");
  chk_upper_zero:
    assert property (s_res_ack |-> o_wb.dat[31:16] == 16'h0) else $error("up");
  chk_reset_quiet:
    assert property ($rose(i_resetn) |-> !o_wb.ack && o_wb.dat == 32'h0)
      else $error("reset value");
  chk_dat_holds:
    assert property ($changed(o_wb.dat) |-> o_wb.ack) else $error("dat moved");
  chk_write_data_zero:
    assert property (o_wb.ack && $past(i_wb.we) |-> o_wb.dat == 32'h0)
      else $error("write answered with data");
endmodule

bind crr_top crr_top_sva u_sva (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_wb(i_wb), .o_wb(o_wb), .i_sample(i_sample));

// file: verif/channel_result_registers_tb_top.sv
`timescale 1ns/10ps
`include "crr_map.svh"

module channel_result_registers_tb_top;
  import crr_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  crr_wb_req_t wb = '0;
  crr_wb_rsp_t o_wb;
  crr_sample_t smp = '0;
  int          error_cnt = 0;
  int          checks = 0;
  localparam logic [7:0] C12 = `CRR_IDX_CHAN12;
  localparam logic [7:0] C13 = `CRR_IDX_CHAN13;
  localparam logic [7:0] CTL = `CRR_IDX_CTRL;
  localparam logic [7:0] STA = `CRR_IDX_STAT;

  crr_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_wb(wb), .o_wb(o_wb),
    .i_sample(smp));

  always #12.5 i_clk = ~i_clk;
  //////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("unexpected %0t got %h want %h", $time, s, e);
    end
  endtask
  // Bus hold until ack; watchdog cuts a hang
  task wbx(input logic w, input logic [7:0] i, input logic [31:0] d,
           output logic [31:0] q);
    wb <= '{1'b1, 1'b1, w, {i, 2'b00}, 4'hf, d};
    @(posedge i_clk);
    while (o_wb.ack !== 1'b1)
      @(posedge i_clk);
    q = o_wb.dat;
    wb <= '0;
    @(posedge i_clk);
  endtask
  task rd(input logic [7:0] i, input logic [13:0] c);
    logic [31:0] q;
    wbx(1'b0, i, 32'h0, q);
    chk(q, {16'h0, c, 2'b00});
  endtask
  task rdw(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] q;
    wbx(1'b0, i, 32'h0, q);
    chk(q, e);
  endtask
  task wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] q;
    wbx(1'b1, i, d, q);
  endtask
  // Valid drops for a full cycle so two samples never share a time step
  task sm(input logic [3:0] ch, input logic [13:0] a, input logic [13:0] f);
    smp <= '{1'b1, ch, a, f};
    @(posedge i_clk);
    smp.valid <= 1'b0;
    @(posedge i_clk);
  endtask
  //////////////////////////////////////////////////////////////////////
  task t_store;
    rd(C12, 14'h0);
    rd(C13, 14'h0);
    sm(4'hc, 14'h3fff, 14'h0001);
    sm(4'hd, 14'h2001, 14'h1555);
    rd(C12, 14'h3fff);
    rd(C13, 14'h2001);
    $display("t_store done");
  endtask
  task t_filt;
    wr(CTL, 32'h7);
    rd(C12, 14'h0001);
    rd(C13, 14'h1555);
    $display("t_filt done");
  endtask
  task t_skip;
    wr(CTL, 32'h6);
    sm(4'hc, 14'h0123, 14'h0456);
    rd(C12, 14'h0001);
    wr(CTL, 32'h2);
    rd(C12, 14'h3fff);
    $display("t_skip done");
  endtask
  task t_ro;
    wr(C12, 32'hffff);
    rd(C12, 14'h3fff);
    rd(8'hff, 14'h0);
    $display("t_ro done");
  endtask
  task t_stat;
    rdw(STA, 32'h4);
    wr(CTL, 32'h3);
    sm(4'hc, 14'h0abc, 14'h0def);
    rdw(STA, 32'h1);
    rd(C12, 14'h0abc);
    rdw(STA, 32'h0);
    $display("t_stat done");
  endtask
  task t_reset;
    wr(CTL, 32'h4);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(C12, 14'h0);
    rd(C13, 14'h0);
    rdw(CTL, 32'h3);
    $display("t_reset done");
  endtask
  task final_report;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_store;
    t_filt;
    t_skip;
    t_ro;
    t_stat;
    t_reset;
    final_report;
  end
  initial
  begin
    #50000;
    error_cnt++;
    final_report;
  end
endmodule
